// *** pkg/mif_pkg.sv ***
// Constants, register map and types of the interrupt flag and mask block
package mif_pkg;

	// ==========================================================
	// Source numbering
	localparam int NUM_SRC = 7;
	localparam int SRC_WAKE = 0;
	localparam int SRC_EXT = 1;
	localparam int SRC_TMR_A = 2;
	localparam int SRC_TMR_B = 3;
	localparam int SRC_TMR_C = 4;
	localparam int SRC_SERIAL = 5;
	localparam int SRC_CONV = 6;

	// ==========================================================
	// Register map (RAM nibble addresses)
	localparam int ADDR_W = 10;
	localparam logic [9:0] WAKE_AND_GLOBAL_CTRL_ADDR = 10'h000;
	localparam logic [9:0] EXTERNAL_IRQ_CTRL_ADDR = 10'h001;
	localparam logic [9:0] TIMER_AB_IRQ_CTRL_ADDR = 10'h002;
	localparam logic [9:0] TIMER_C_CONV_IRQ_CTRL_ADDR = 10'h003;
	localparam logic [9:0] SERIAL_IRQ_CTRL_ADDR = 10'h023;

	// Global enable position
	localparam logic [1:0] GLOBAL_IRQ_ENABLE_BIT = 2'h0;

	// Per source flag and mask placement, indexed by source number
	localparam logic [9:0] FLAG_ADDR [NUM_SRC] = '{
		WAKE_AND_GLOBAL_CTRL_ADDR, EXTERNAL_IRQ_CTRL_ADDR,
		TIMER_AB_IRQ_CTRL_ADDR, TIMER_AB_IRQ_CTRL_ADDR,
		TIMER_C_CONV_IRQ_CTRL_ADDR, SERIAL_IRQ_CTRL_ADDR,
		TIMER_C_CONV_IRQ_CTRL_ADDR};
	localparam logic [1:0] FLAG_BIT [NUM_SRC] = '{
		2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2};
	localparam logic [1:0] MASK_BIT [NUM_SRC] = '{
		2'h3, 2'h1, 2'h1, 2'h3, 2'h1, 2'h3, 2'h3};

	// ==========================================================
	// Reset values
	localparam logic GLOBAL_IRQ_ENABLE_RST = 1'h0;
	localparam logic [NUM_SRC-1:0] FLAG_RST = 7'h00;
	localparam logic [NUM_SRC-1:0] MASK_RST = 7'h7f;
	localparam logic PIN_IDLE = 1'h1;

	// ==========================================================
	// Priority levels presented to the sequencer
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [2:0] LVL_WAKE = 3'h1;
	localparam logic [2:0] LVL_EXT = 3'h2;
	localparam logic [2:0] LVL_TMR_A = 3'h3;
	localparam logic [2:0] LVL_TMR_B = 3'h4;
	localparam logic [2:0] LVL_TMR_C = 3'h5;
	localparam logic [2:0] LVL_SER_CONV = 3'h6;

	// ==========================================================
	// Oscillation settling wait
	localparam int SETTLE_W = 16;
	localparam int SETTLE_CYCLES_DEF = 256;

	typedef enum logic [0:0] {
		WK_IDLE,
		WK_SETTLE
	} mif_wake_state_t;

endpackage : mif_pkg

// *** rtl/mif_fall_sync.sv ***
// Two-stage pin synchroniser with a falling edge detector
`timescale 1ns/1ps
module mif_fall_sync (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic pin_in,
	output logic      fall_out
);

	// ==========================================================
	// Synchroniser; the first stage feeds only the second
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= mif_pkg::PIN_IDLE;
			sync_r <= mif_pkg::PIN_IDLE;
			prev_r <= mif_pkg::PIN_IDLE;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// ==========================================================
	// Edge, one cycle wide
	assign fall_out = prev_r & ~sync_r;

endmodule : mif_fall_sync

// *** rtl/mif_irq_ctrl.sv ***
// Interrupt request flags, masks, global enable and priority selection
`timescale 1ns/1ps
// Notes on behaviour
// - Global enable 0 blocks all requests
// - Wake pin fall sets wake flag outside stop
// - Wake fall in stop waits settling, then wakes
// - Stop exit with enable, unmasked: handle without flag
// - Wake mask 0 passes, 1 holds pending
// - External pin fall sets external flag
// - External mask 0 passes, 1 holds pending
// - Timer A overflow sets timer A flag
// - Timer A mask 0 passes, 1 holds pending
// - Timer B overflow sets timer B flag
// - Timer B mask 0 passes, 1 holds pending
// - Timer C overflow sets timer C flag
// - Timer C mask 0 passes, 1 holds pending
// - Serial done or abort sets serial flag
// - Serial mask 0 passes, 1 holds pending
// - Conversion done sets converter flag
// - Converter mask 0 passes, 1 holds pending
// - Request is flag 1 and mask 0
// - Fixed priority; serial and converter share last
// - Reset clears enable, flags; sets masks
// - Accept clears enable; return sets it
module mif_irq_ctrl #(
	parameter int SETTLE_CYCLES = mif_pkg::SETTLE_CYCLES_DEF
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// Pins
	input  wire logic        wake_pin_in,
	input  wire logic        ext_irq_pin_in,
	// Peripheral event pulses
	input  wire logic        tmr_a_ovf_in,
	input  wire logic        tmr_b_ovf_in,
	input  wire logic        tmr_c_ovf_in,
	input  wire logic        serial_done_in,
	input  wire logic        serial_abort_in,
	input  wire logic        conv_done_in,
	// Mode controller
	input  wire logic        stop_mode_in,
	output logic             stop_wake_out,
	// RAM bit access from the core
	input  wire logic [9:0]  ram_addr_in,
	input  wire logic        ram_wr_in,
	input  wire logic [3:0]  ram_bit_sel_in,
	input  wire logic [3:0]  ram_wdata_in,
	input  wire logic        ram_rd_in,
	output logic [3:0]       ram_rdata_out,
	output logic             ram_hit_out,
	// Interrupt sequencer
	input  wire logic        irq_accept_in,
	input  wire logic        return_from_irq_instr_in,
	output logic             irq_req_out,
	output logic [2:0]       irq_level_out,
	output logic             global_irq_enable_out
);

	localparam int N = mif_pkg::NUM_SRC;
	localparam logic [mif_pkg::SETTLE_W-1:0] SETTLE_LAST =
		mif_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

	// ==========================================================
	// Pin edge detection
	// Both pins are asynchronous, so each passes two flops before use
	logic wake_fall;
	logic ext_fall;

	mif_fall_sync u_wake_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.pin_in     (wake_pin_in),
		.fall_out   (wake_fall)
	);

	mif_fall_sync u_ext_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.pin_in     (ext_irq_pin_in),
		.fall_out   (ext_fall)
	);

	// ==========================================================
	// State
	logic                         global_irq_enable_r;
	logic [N-1:0]                 req_flag_r;
	logic [N-1:0]                 req_mask_r;
	logic                         stop_wake_pend_r;
	logic                         stop_wake_r;
	mif_pkg::mif_wake_state_t     wk_state_r;
	logic [mif_pkg::SETTLE_W-1:0] settle_cnt_r;
	logic                         irq_req_r;
	logic [2:0]                   irq_level_r;
	logic [3:0]                   ram_rdata_r;
	logic                         ram_hit_r;

	// ==========================================================
	// Source event vector
	logic [N-1:0] src_set;

	always_comb begin
		src_set = '0;
		src_set[mif_pkg::SRC_WAKE] = wake_fall & ~stop_mode_in;
		src_set[mif_pkg::SRC_EXT] = ext_fall;
		src_set[mif_pkg::SRC_TMR_A] = tmr_a_ovf_in;
		src_set[mif_pkg::SRC_TMR_B] = tmr_b_ovf_in;
		src_set[mif_pkg::SRC_TMR_C] = tmr_c_ovf_in;
		src_set[mif_pkg::SRC_SERIAL] = serial_done_in | serial_abort_in;
		src_set[mif_pkg::SRC_CONV] = conv_done_in;
	end

	// ==========================================================
	// Write decode
	logic [N-1:0]      flag_clr;
	logic [N-1:0]      mask_wr;
	logic              ie_wr;
	logic [N-1:0][3:0] rd_src;
	logic [N-1:0]      rd_src_hit;

	assign ie_wr = ram_wr_in
		& (ram_addr_in == mif_pkg::WAKE_AND_GLOBAL_CTRL_ADDR)
		& ram_bit_sel_in[mif_pkg::GLOBAL_IRQ_ENABLE_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_src
			logic addr_hit;

			assign addr_hit = ram_wr_in & (ram_addr_in == mif_pkg::FLAG_ADDR[gi]);
			// Writing 1 to a flag is ignored; software cannot raise one
			assign flag_clr[gi] = addr_hit
				& ram_bit_sel_in[mif_pkg::FLAG_BIT[gi]]
				& ~ram_wdata_in[mif_pkg::FLAG_BIT[gi]];
			assign mask_wr[gi] = addr_hit & ram_bit_sel_in[mif_pkg::MASK_BIT[gi]];

			// Hardware set wins over a clear in the same cycle
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					req_flag_r[gi] <= mif_pkg::FLAG_RST[gi];
				end else if (src_set[gi]) begin
					req_flag_r[gi] <= 1'b1;
				end else if (flag_clr[gi]) begin
					req_flag_r[gi] <= 1'b0;
				end
			end

			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					req_mask_r[gi] <= mif_pkg::MASK_RST[gi];
				end else if (mask_wr[gi]) begin
					req_mask_r[gi] <= ram_wdata_in[mif_pkg::MASK_BIT[gi]];
				end
			end

			// Each source drives only its own two bits of the addressed nibble
			assign rd_src_hit[gi] = (ram_addr_in == mif_pkg::FLAG_ADDR[gi]);

			always_comb begin
				rd_src[gi] = '0;
				if (rd_src_hit[gi]) begin
					rd_src[gi][mif_pkg::FLAG_BIT[gi]] = req_flag_r[gi];
					rd_src[gi][mif_pkg::MASK_BIT[gi]] = req_mask_r[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Global enable
	// Accept beats return, which beats a software write
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			global_irq_enable_r <= mif_pkg::GLOBAL_IRQ_ENABLE_RST;
		end else if (irq_accept_in) begin
			global_irq_enable_r <= 1'b0;
		end else if (return_from_irq_instr_in) begin
			global_irq_enable_r <= 1'b1;
		end else if (ie_wr) begin
			global_irq_enable_r <= ram_wdata_in[mif_pkg::GLOBAL_IRQ_ENABLE_BIT];
		end
	end

	// ==========================================================
	// Stop mode wake-up and settling wait
	logic settle_done;
	logic wake_pend_set;
	logic wake_pend_clr;

	assign settle_done = (wk_state_r == mif_pkg::WK_SETTLE) & (settle_cnt_r == SETTLE_LAST);
	assign wake_pend_set = settle_done & global_irq_enable_r
		& ~req_mask_r[mif_pkg::SRC_WAKE];
	assign wake_pend_clr = irq_accept_in & (irq_level_r == mif_pkg::LVL_WAKE);

	// An edge seen while already waiting is ignored; the wait starts only from idle
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wk_state_r <= mif_pkg::WK_IDLE;
		end else begin
			case (wk_state_r)
				mif_pkg::WK_IDLE: begin
					if (stop_mode_in & wake_fall) begin
						wk_state_r <= mif_pkg::WK_SETTLE;
					end
				end
				mif_pkg::WK_SETTLE: begin
					if (settle_done) begin
						wk_state_r <= mif_pkg::WK_IDLE;
					end
				end
				default: begin
					wk_state_r <= mif_pkg::WK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			settle_cnt_r <= '0;
		end else if (wk_state_r == mif_pkg::WK_SETTLE) begin
			settle_cnt_r <= settle_cnt_r + 1'b1;
		end else begin
			settle_cnt_r <= '0;
		end
	end

	// One-cycle request to the mode controller to enter active mode
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stop_wake_r <= 1'b0;
		end else begin
			stop_wake_r <= settle_done;
		end
	end

	// Wake handling after stop exit is held here, not in the flag
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stop_wake_pend_r <= 1'b0;
		end else if (wake_pend_set) begin
			stop_wake_pend_r <= 1'h1;
		end else if (wake_pend_clr) begin
			stop_wake_pend_r <= 1'b0;
		end
	end

	// ==========================================================
	// Request qualification and priority
	logic [N-1:0] src_req;
	logic [2:0]   level_nxt;
	logic         any_req;

	always_comb begin
		src_req = req_flag_r & ~req_mask_r;
		src_req[mif_pkg::SRC_WAKE] = src_req[mif_pkg::SRC_WAKE] | stop_wake_pend_r;
	end

	assign any_req = |src_req;

	always_comb begin
		level_nxt = mif_pkg::LVL_NONE;
		if (src_req[mif_pkg::SRC_WAKE]) begin
			level_nxt = mif_pkg::LVL_WAKE;
		end else if (src_req[mif_pkg::SRC_EXT]) begin
			level_nxt = mif_pkg::LVL_EXT;
		end else if (src_req[mif_pkg::SRC_TMR_A]) begin
			level_nxt = mif_pkg::LVL_TMR_A;
		end else if (src_req[mif_pkg::SRC_TMR_B]) begin
			level_nxt = mif_pkg::LVL_TMR_B;
		end else if (src_req[mif_pkg::SRC_TMR_C]) begin
			level_nxt = mif_pkg::LVL_TMR_C;
		end else if (src_req[mif_pkg::SRC_SERIAL] | src_req[mif_pkg::SRC_CONV]) begin
			level_nxt = mif_pkg::LVL_SER_CONV;
		end
	end

	// Dropped in the accept cycle so a stale request is never seen twice
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_req_r <= 1'h0;
		end else begin
			irq_req_r <= global_irq_enable_r & ~irq_accept_in & any_req;
		end
	end

	// Level is shown even while disabled, so software can poll the winner
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_level_r <= mif_pkg::LVL_NONE;
		end else begin
			irq_level_r <= level_nxt;
		end
	end

	// ==========================================================
	// Read side
	logic [3:0] rd_nib;
	logic       rd_hit;
	logic       ram_acc;

	always_comb begin
		rd_nib = '0;
		rd_hit = |rd_src_hit;
		if (ram_addr_in == mif_pkg::WAKE_AND_GLOBAL_CTRL_ADDR) begin
			rd_nib[mif_pkg::GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_r;
			rd_hit = 1'h1;
		end
		// Unaddressed sources give zero, so an OR merges them
		for (int i = 0; i < N; i++) begin
			rd_nib = rd_nib | rd_src[i];
		end
	end

	// A write counts as an access for the hit flag too
	assign ram_acc = ram_rd_in | ram_wr_in;

	// Data holds until the next read
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ram_rdata_r <= '0;
		end else if (ram_rd_in) begin
			ram_rdata_r <= rd_nib;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ram_hit_r <= 1'b0;
		end else begin
			ram_hit_r <= ram_acc & rd_hit;
		end
	end

	// ==========================================================
	// Outputs
	assign stop_wake_out = stop_wake_r;
	assign ram_rdata_out = ram_rdata_r;
	assign ram_hit_out = ram_hit_r;
	assign irq_req_out = irq_req_r;
	assign irq_level_out = irq_level_r;
	assign global_irq_enable_out = global_irq_enable_r;

endmodule : mif_irq_ctrl

// *** rtl/mif_wake_alias_fix.sv ***
// Spare design file; it holds no logic

// *** bench/mif_irq_ctrl_sva.sv ***
// Port checker for the interrupt flag and mask block
`timescale 1ns/1ps
module mif_irq_ctrl_sva (
	input wire logic       clk_sys_in,
	input wire logic       reset_n_in,
	input wire logic [9:0] ram_addr_in,
	input wire logic       ram_wr_in,
	input wire logic       ram_rd_in,
	input wire logic [3:0] ram_rdata_out,
	input wire logic       ram_hit_out,
	input wire logic       irq_accept_in,
	input wire logic       return_from_irq_instr_in,
	input wire logic       irq_req_out,
	input wire logic [2:0] irq_level_out,
	input wire logic       global_irq_enable_out,
	input wire logic       stop_wake_out
);
	// ==========
	// Decode
	logic mapped;
	assign mapped = ram_addr_in inside {10'h000, 10'h001, 10'h002, 10'h003, 10'h023};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	// ==========
	// Properties
	a_reset_quiet: assert property ($rose(reset_n_in) |->
		!global_irq_enable_out && !irq_req_out && irq_level_out == 3'h0)
		else $error("outputs not idle after reset");
	a_accept_clears: assert property (irq_accept_in |=>
		!global_irq_enable_out && !irq_req_out) else $error("accept did not clear");
	a_return_sets: assert property (return_from_irq_instr_in && !irq_accept_in |=>
		global_irq_enable_out) else $error("return did not set enable");
	a_enable_gate: assert property (!global_irq_enable_out &&
		!$past(global_irq_enable_out) |-> !irq_req_out) else $error("request while disabled");
	a_req_level: assert property (irq_req_out |->
		irq_level_out inside {[3'h1:3'h6]}) else $error("request without level");
	a_level_range: assert property (irq_level_out <= 3'h6)
		else $error("level out of range");
	a_unmapped_read: assert property (ram_rd_in && !mapped |=>
		!ram_hit_out && ram_rdata_out == 4'h0) else $error("unmapped read answered");
	a_mapped_hit: assert property ((ram_rd_in || ram_wr_in) && mapped |=> ram_hit_out)
		else $error("mapped access missed");
	a_unused_zero: assert property (ram_rd_in && ram_addr_in == 10'h001 |=>
		ram_rdata_out[3:2] == 2'h0) else $error("unused bits not zero");
	a_rdata_hold: assert property (!ram_rd_in |=> $stable(ram_rdata_out))
		else $error("read data moved");
	a_wake_pulse: assert property (stop_wake_out |=> !stop_wake_out)
		else $error("wake pulse too long");
endmodule : mif_irq_ctrl_sva
bind mif_irq_ctrl mif_irq_ctrl_sva chk (
	.clk_sys_in               (clk_sys_in),
	.reset_n_in               (reset_n_in),
	.ram_addr_in              (ram_addr_in),
	.ram_wr_in                (ram_wr_in),
	.ram_rd_in                (ram_rd_in),
	.ram_rdata_out            (ram_rdata_out),
	.ram_hit_out              (ram_hit_out),
	.irq_accept_in            (irq_accept_in),
	.return_from_irq_instr_in (return_from_irq_instr_in),
	.irq_req_out              (irq_req_out),
	.irq_level_out            (irq_level_out),
	.global_irq_enable_out    (global_irq_enable_out),
	.stop_wake_out            (stop_wake_out)
);

// *** bench/mif_seq_model.sv ***
// Behavioural interrupt sequencer on the far side
`timescale 1ns/1ps
module mif_seq_model #(
	parameter int DELAY = 2
) (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic irq_req_in,
	input  wire logic auto_en_in,
	output logic      accept_out
);
	// ==========
	// Accept
	logic [3:0] wait_r;
	// Late accept, as a core finishing its instruction; one pulse so the drop is seen
	always_ff @(negedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_r <= 4'h0;
			accept_out <= 1'b0;
		end else if (accept_out || !irq_req_in || !auto_en_in) begin
			wait_r <= 4'h0;
			accept_out <= 1'b0;
		end else if (wait_r == 4'(DELAY)) begin
			accept_out <= 1'b1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule : mif_seq_model

// *** bench/mif_irq_ctrl_tb_top.sv ***
// Testbench for the interrupt flag and mask block
`timescale 1ns/1ps
module mif_irq_ctrl_tb_top;
	// ==========
	// Signals
	logic       clk_sys_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic       wake_pin_in = 1'b1;
	logic       ext_irq_pin_in = 1'b1;
	logic       tmr_a_ovf_in = 1'b0;
	logic       tmr_b_ovf_in = 1'b0;
	logic       tmr_c_ovf_in = 1'b0;
	logic       serial_done_in = 1'b0;
	logic       serial_abort_in = 1'b0;
	logic       conv_done_in = 1'b0;
	logic       stop_mode_in = 1'b0;
	logic [9:0] ram_addr_in = 10'h000;
	logic       ram_wr_in = 1'b0;
	logic [3:0] ram_bit_sel_in = 4'h0;
	logic [3:0] ram_wdata_in = 4'h0;
	logic       ram_rd_in = 1'b0;
	logic       return_from_irq_instr_in = 1'b0;
	logic       auto_acc = 1'b0;
	logic       irq_accept_in;
	logic       stop_wake_out;
	logic [3:0] ram_rdata_out;
	logic       ram_hit_out;
	logic       irq_req_out;
	logic [2:0] irq_level_out;
	logic       global_irq_enable_out;
	int         miscompares = 0;
	int         cmp_count = 0;
	int         n;
	// Mask address and bit of each source, highest priority first
	localparam logic [9:0] MA [7] = '{10'h000, 10'h001, 10'h002, 10'h002, 10'h003, 10'h003,
		10'h023};
	localparam logic [3:0] MS [7] = '{4'h8, 4'h2, 4'h2, 4'h8, 4'h2, 4'h8, 4'h8};
	always #20 clk_sys_in = ~clk_sys_in;
	mif_irq_ctrl #(.SETTLE_CYCLES(4)) uut (
		.clk_sys_in               (clk_sys_in),
		.reset_n_in               (reset_n_in),
		.wake_pin_in              (wake_pin_in),
		.ext_irq_pin_in           (ext_irq_pin_in),
		.tmr_a_ovf_in             (tmr_a_ovf_in),
		.tmr_b_ovf_in             (tmr_b_ovf_in),
		.tmr_c_ovf_in             (tmr_c_ovf_in),
		.serial_done_in           (serial_done_in),
		.serial_abort_in          (serial_abort_in),
		.conv_done_in             (conv_done_in),
		.stop_mode_in             (stop_mode_in),
		.stop_wake_out            (stop_wake_out),
		.ram_addr_in              (ram_addr_in),
		.ram_wr_in                (ram_wr_in),
		.ram_bit_sel_in           (ram_bit_sel_in),
		.ram_wdata_in             (ram_wdata_in),
		.ram_rd_in                (ram_rd_in),
		.ram_rdata_out            (ram_rdata_out),
		.ram_hit_out              (ram_hit_out),
		.irq_accept_in            (irq_accept_in),
		.return_from_irq_instr_in (return_from_irq_instr_in),
		.irq_req_out              (irq_req_out),
		.irq_level_out            (irq_level_out),
		.global_irq_enable_out    (global_irq_enable_out)
	);
	mif_seq_model sq (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.irq_req_in(irq_req_out), .auto_en_in(auto_acc), .accept_out(irq_accept_in));
	// ==========
	// Tasks
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [9:0] a, input logic [3:0] s, input logic [3:0] d);
		@(negedge clk_sys_in);
		ram_addr_in = a;
		ram_bit_sel_in = s;
		ram_wdata_in = d;
		ram_wr_in = 1'b1;
		@(negedge clk_sys_in);
		ram_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [3:0] e);
		@(negedge clk_sys_in);
		ram_addr_in = a;
		ram_rd_in = 1'b1;
		@(negedge clk_sys_in);
		ram_rd_in = 1'b0;
		chk(ram_rdata_out, e);
		chk({3'h0, ram_hit_out}, {3'h0, (a <= 10'h003) || (a == 10'h023)});
	endtask : rd
	task automatic pulse(input logic [5:0] v);
		@(negedge clk_sys_in);
		{conv_done_in, serial_abort_in, serial_done_in, tmr_c_ovf_in, tmr_b_ovf_in,
			tmr_a_ovf_in} = v;
		@(negedge clk_sys_in);
		{conv_done_in, serial_abort_in, serial_done_in, tmr_c_ovf_in, tmr_b_ovf_in,
			tmr_a_ovf_in} = 6'h00;
	endtask : pulse
	task automatic fall(input logic w);
		@(negedge clk_sys_in);
		if (w) wake_pin_in = 1'b0;
		else ext_irq_pin_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		wake_pin_in = 1'b1;
		ext_irq_pin_in = 1'b1;
	endtask : fall
	// ==========
	// Scenarios
	task automatic s_reset;
		logic [9:0] ad [6] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h023, 10'h004};
		logic [3:0] ex [6] = '{4'h8, 4'h2, 4'ha, 4'ha, 4'h8, 4'h0};
		for (int i = 0; i < 6; i++) rd(ad[i], ex[i]);
	endtask : s_reset
	task automatic s_events;
		pulse(6'h27);
		rd(10'h002, 4'hf);
		rd(10'h003, 4'hf);
		pulse(6'h08);
		rd(10'h023, 4'hc);
		wr(10'h023, 4'h4, 4'h0);
		pulse(6'h10);
		rd(10'h023, 4'hc);
		fall(1'b0);
		rd(10'h001, 4'h3);
		fall(1'b1);
		rd(10'h000, 4'hc);
	endtask : s_events
	task automatic s_prio;
		wr(10'h000, 4'h1, 4'h1);
		for (int i = 0; i < 7; i++) wr(MA[i], MS[i], 4'h0);
		@(negedge clk_sys_in);
		wr(10'h000, 4'h1, 4'h0);
		@(negedge clk_sys_in);
		chk({3'h0, irq_req_out}, 4'h0);
		wr(10'h000, 4'h1, 4'h1);
		@(negedge clk_sys_in);
		for (int i = 0; i < 7; i++) begin
			chk({irq_req_out, irq_level_out}, {1'b1, (i < 5) ? 3'(i + 1) : 3'h6});
			wr(MA[i], MS[i], 4'hf);
			@(negedge clk_sys_in);
		end
		chk({irq_req_out, irq_level_out}, 4'h0);
		wr(10'h000, 4'h4, 4'h0);
		wr(10'h001, 4'h1, 4'h0);
		wr(10'h002, 4'h5, 4'h0);
		wr(10'h003, 4'h5, 4'h0);
		wr(10'h023, 4'h4, 4'h0);
		wr(10'h002, 4'h5, 4'hf);
		rd(10'h002, 4'ha);
		rd(10'h000, 4'h9);
	endtask : s_prio
	task automatic s_accept;
		wr(10'h002, 4'h2, 4'h0);
		auto_acc = 1'b1;
		pulse(6'h01);
		for (n = 0; n < 20 && global_irq_enable_out !== 1'b0; n++) @(negedge clk_sys_in);
		if (n == 20) begin
			chk(4'h0, 4'h1);
			stop_test();
		end
		chk({3'h0, irq_req_out}, 4'h0);
		auto_acc = 1'b0;
		rd(10'h002, 4'h9);
		return_from_irq_instr_in = 1'b1;
		@(negedge clk_sys_in);
		return_from_irq_instr_in = 1'b0;
		chk({3'h0, global_irq_enable_out}, 4'h1);
		wr(10'h002, 4'h3, 4'h2);
	endtask : s_accept
	task automatic s_stop;
		wr(10'h000, 4'h8, 4'h0);
		stop_mode_in = 1'b1;
		@(negedge clk_sys_in);
		wake_pin_in = 1'b0;
		for (n = 0; n < 40 && stop_wake_out !== 1'b1; n++) @(negedge clk_sys_in);
		if (n == 40) begin
			chk(4'h0, 4'h1);
			stop_test();
		end
		stop_mode_in = 1'b0;
		wake_pin_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		chk({irq_req_out, irq_level_out}, 4'h9);
		rd(10'h000, 4'h1);
	endtask : s_stop
	// ==========
	// Main sequence
	initial begin
		repeat (6) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		s_reset();
		s_events();
		s_prio();
		s_accept();
		s_stop();
		stop_test();
	end
endmodule : mif_irq_ctrl_tb_top
